// [hdl/daao_cc_if.sv]
// Purpose: Carries CC terminations and VBUS drive between the debug port and the target port.
// Assumes: Each party drives only its own terminations and its own VBUS enable.
// Notes:   The VBUS wire level is the OR of both enables.
`timescale 1ns/1ps
`default_nettype none
interface daao_cc_if;
  import daao_pkg::*;

  daao_term_t dts_cc1;
  daao_term_t dts_cc2;
  daao_term_t tgt_cc1;
  daao_term_t tgt_cc2;
  logic       dts_vbus_en;
  logic       tgt_vbus_en;
  wire        vbus;

  assign vbus = dts_vbus_en | tgt_vbus_en;

  modport dts (output dts_cc1, output dts_cc2, output dts_vbus_en,
               input tgt_cc1, input tgt_cc2, input vbus);
  modport tgt (output tgt_cc1, output tgt_cc2, output tgt_vbus_en,
               input dts_cc1, input dts_cc2, input vbus);
endinterface
`default_nettype wire

// [hdl/daao_dts.sv]
// Purpose: Debug test system end: idle toggling, attach-wait, attached and orientation drive.
// Assumes: The far terminations and VBUS arrive asynchronously and are synchronised here.
// Notes:   ROLE picks source, sink or dual-role; ORIENT_EN enables asymmetric signalling.
`timescale 1ns/1ps
`default_nettype none
module daao_dts
  import daao_pkg::*;
#(
  parameter int ROLE       = DAAO_ROLE_DRP,
  parameter bit ORIENT_EN  = 1'b1,
  parameter int DEB_CYC    = DAAO_DEB_CYC,
  parameter int TOGGLE_CYC = DAAO_TOGGLE_CYC
) (
  input  wire logic CLK,
  input  wire logic RST_N,
  daao_cc_if.dts    CC,
  output logic      ATTACH_WAIT,
  output logic      ATTACHED,
  output logic      IS_SOURCE
);

  if (ROLE < DAAO_ROLE_SRC || ROLE > DAAO_ROLE_DRP || DEB_CYC < 1 || TOGGLE_CYC < 1) begin : g_chk
    $error("daao_dts: unsupported parameter value");
  end

  localparam int CW = $clog2(DEB_CYC + TOGGLE_CYC + 1) + 1;
  localparam logic [CW-1:0] DEB_C = CW'(DEB_CYC);
  localparam logic [CW-1:0] TOG_C = CW'(TOGGLE_CYC);
  localparam logic [CW-1:0] MAX_C = {CW{1'b1}};

  typedef enum logic [2:0] {
    S_IDLE_SRC, S_AW_SRC, S_ATT_SRC, S_IDLE_SNK, S_AW_SNK, S_ATT_SNK
  } daao_dts_state_t;

  localparam daao_dts_state_t S_HOME = (ROLE == DAAO_ROLE_SNK) ? S_IDLE_SNK : S_IDLE_SRC;

  daao_term_t      cc1_s1_r, cc1_s2_r, cc1_s3_r;
  daao_term_t      cc2_s1_r, cc2_s2_r, cc2_s3_r;
  logic            vb_s1_r, vb_s2_r, vb_s3_r;
  daao_dts_state_t st_r, st_nxt;
  logic [CW-1:0]   cnt_r, cnt_nxt;
  daao_term_t      cc1_out_r, cc2_out_r, cc1_nxt, cc2_nxt;
  logic            vbus_en_r;

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      cc1_s1_r <= DAAO_TERM_OPEN;
      cc1_s2_r <= DAAO_TERM_OPEN;
      cc1_s3_r <= DAAO_TERM_OPEN;
      cc2_s1_r <= DAAO_TERM_OPEN;
      cc2_s2_r <= DAAO_TERM_OPEN;
      cc2_s3_r <= DAAO_TERM_OPEN;
      vb_s1_r  <= 1'b0;
      vb_s2_r  <= 1'b0;
      vb_s3_r  <= 1'b0;
    end else begin
      cc1_s1_r <= CC.tgt_cc1;
      cc1_s2_r <= cc1_s1_r;
      cc1_s3_r <= cc1_s2_r;
      cc2_s1_r <= CC.tgt_cc2;
      cc2_s2_r <= cc2_s1_r;
      cc2_s3_r <= cc2_s2_r;
      vb_s1_r  <= CC.vbus;
      vb_s2_r  <= vb_s1_r;
      vb_s3_r  <= vb_s2_r;
    end
  end

  wire both_pu   = daao_is_pu(cc1_s2_r) && daao_is_pu(cc2_s2_r);
  wire both_pd   = daao_is_pd(cc1_s2_r) && daao_is_pd(cc2_s2_r);
  wire both_open = (cc1_s2_r == DAAO_TERM_OPEN) && (cc2_s2_r == DAAO_TERM_OPEN);
  wire is_drp    = (ROLE == DAAO_ROLE_DRP);
  wire deb_done  = (cnt_r >= DEB_C);
  wire tog_done  = (cnt_r >= TOG_C);
  wire in_change = (cc1_s2_r != cc1_s3_r) || (cc2_s2_r != cc2_s3_r) || (vb_s2_r != vb_s3_r);

  always_comb begin
    st_nxt = st_r;
    unique case (st_r)
      S_IDLE_SRC: begin
        if (both_pd) st_nxt = S_AW_SRC;
        else if (is_drp && tog_done) st_nxt = S_IDLE_SNK;
      end
      S_AW_SRC: begin
        if (!both_pd) st_nxt = S_IDLE_SRC;
        else if (deb_done) st_nxt = S_ATT_SRC;
      end
      S_ATT_SRC: begin
        if (both_open) st_nxt = S_IDLE_SRC;
      end
      S_IDLE_SNK: begin
        if (both_pu) st_nxt = S_AW_SNK;
        else if (is_drp && tog_done) st_nxt = S_IDLE_SRC;
      end
      S_AW_SNK: begin
        if (both_open) st_nxt = S_HOME;
        else if (both_pu && vb_s2_r && deb_done) st_nxt = S_ATT_SNK;
      end
      S_ATT_SNK: begin
        if (both_open) st_nxt = S_HOME;
        else if (!vb_s2_r) st_nxt = S_AW_SNK;
      end
      default: st_nxt = S_HOME;
    endcase
  end

  wire nxt_src = (st_nxt == S_IDLE_SRC) || (st_nxt == S_AW_SRC) || (st_nxt == S_ATT_SRC);

  always_comb begin
    cnt_nxt = (in_change || (st_nxt != st_r)) ? '0 : ((cnt_r == MAX_C) ? cnt_r : cnt_r + 1'b1);
    if (nxt_src) begin
      cc1_nxt = DAAO_TERM_RP_STRONG;
      cc2_nxt = ORIENT_EN ? DAAO_TERM_RP_WEAK : DAAO_TERM_RP_STRONG;
    end else begin
      cc1_nxt = DAAO_TERM_RD;
      cc2_nxt = (ORIENT_EN && st_nxt == S_ATT_SNK) ? DAAO_TERM_RA : DAAO_TERM_RD;
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      st_r      <= S_HOME;
      cnt_r     <= '0;
      cc1_out_r <= (ROLE == DAAO_ROLE_SNK) ? DAAO_TERM_RD : DAAO_TERM_RP_STRONG;
      cc2_out_r <= (ROLE == DAAO_ROLE_SNK) ? DAAO_TERM_RD
                 : (ORIENT_EN ? DAAO_TERM_RP_WEAK : DAAO_TERM_RP_STRONG);
      vbus_en_r <= 1'b0;
    end else begin
      st_r      <= st_nxt;
      cnt_r     <= cnt_nxt;
      cc1_out_r <= cc1_nxt;
      cc2_out_r <= cc2_nxt;
      vbus_en_r <= (st_nxt == S_ATT_SRC);
    end
  end

  assign CC.dts_cc1     = cc1_out_r;
  assign CC.dts_cc2     = cc2_out_r;
  assign CC.dts_vbus_en = vbus_en_r;
  assign ATTACH_WAIT    = (st_r == S_AW_SRC) || (st_r == S_AW_SNK);
  assign ATTACHED       = (st_r == S_ATT_SRC) || (st_r == S_ATT_SNK);
  assign IS_SOURCE      = (st_r == S_IDLE_SRC) || (st_r == S_AW_SRC) || (st_r == S_ATT_SRC);

endmodule
`default_nettype wire

// [hdl/daao_pkg.sv]
// Purpose: Shared constants, types and helpers for the debug accessory attach and orientation ends.
// Assumes: Both ends run on one 100 MHz clock; CC terminations are carried as abstract codes.
// Notes:   What this block does
// What this block does
// - Dual-role debug port toggles source/sink while idle.
// - Debug sink sees pull-ups on both pins.
// - Debug sink waits without VBUS, never attached.
// - Plain target source enters attach-wait on pull-downs.
// - Plain target source stays waiting on double pull-downs.
// - Plain target source returns idle on detach.
// - Dual-role debug port returns idle source when open.
// - Accessory target sink toggles sink/accessory while idle.
// - Accessory target sink enters debug mode on pull-downs.
// - Target sink returns idle sink on detach.
// - Debug sink returns idle sink when open.
// - Debug port always starts orientation sequence.
// - Debug source drives weaker pull-up on pin two.
// - Target sink orients after settle time stability.
// - Higher-voltage pin becomes the plug CC pin.
// - Target sink gates messaging until oriented.
// - Debug sink first presents pull-downs on both.
// - Attached debug sink drops pin two to accessory.
// - Target source detects asymmetry, becomes oriented.
// - Target source orients once accessory level seen.
// - Target source gates messaging until oriented.
package daao_pkg;

  // Termination a party places on one CC pin.
  typedef enum logic [2:0] {
    DAAO_TERM_OPEN,
    DAAO_TERM_RD,
    DAAO_TERM_RA,
    DAAO_TERM_RP_STRONG,
    DAAO_TERM_RP_WEAK
  } daao_term_t;

  localparam int DAAO_ROLE_SRC = 0;
  localparam int DAAO_ROLE_SNK = 1;
  localparam int DAAO_ROLE_DRP = 2;

  localparam int DAAO_KIND_SRC     = 0;
  localparam int DAAO_KIND_SNK_ACC = 1;

  // Interval counts in cycles of CLK (no figures are given, so these are plain defaults).
  localparam int DAAO_DEB_CYC    = 16;
  localparam int DAAO_SETTLE_CYC = 24;
  localparam int DAAO_TOGGLE_CYC = 32;

  function automatic logic daao_is_pu(input daao_term_t t);
    return (t == DAAO_TERM_RP_STRONG) || (t == DAAO_TERM_RP_WEAK);
  endfunction

  function automatic logic daao_is_pd(input daao_term_t t);
    return (t == DAAO_TERM_RD) || (t == DAAO_TERM_RA);
  endfunction

endpackage

// [hdl/daao_target.sv]
// Purpose: Target system end: source or accessory-capable sink, with or without debug mode.
// Assumes: The far terminations and VBUS arrive asynchronously and are synchronised here.
// Notes:   KIND picks source or sink with accessory support; DAM_EN enables debug mode except on the accessory path, which enters it regardless.
`timescale 1ns/1ps
`default_nettype none
module daao_target
  import daao_pkg::*;
#(
  parameter int KIND       = DAAO_KIND_SRC,
  parameter bit DAM_EN     = 1'b0,
  parameter int DEB_CYC    = DAAO_DEB_CYC,
  parameter int SETTLE_CYC = DAAO_SETTLE_CYC,
  parameter int TOGGLE_CYC = DAAO_TOGGLE_CYC
) (
  input  wire logic CLK,
  input  wire logic RST_N,
  daao_cc_if.tgt    CC,
  output logic      ATTACH_WAIT,
  output logic      ATTACHED,
  output logic      DEBUG_MODE,
  output logic      ORIENTED,
  output logic      PLUG_CC2,
  output logic      PD_EN,
  output logic      DBG_CONNECT
);

  if (KIND < DAAO_KIND_SRC || KIND > DAAO_KIND_SNK_ACC || DEB_CYC < 1 || SETTLE_CYC < 1 ||
      TOGGLE_CYC < 1) begin : g_chk
    $error("daao_target: unsupported parameter value");
  end

  localparam int CW = $clog2(DEB_CYC + SETTLE_CYC + TOGGLE_CYC + 1) + 1;
  localparam logic [CW-1:0] DEB_C = CW'(DEB_CYC);
  localparam logic [CW-1:0] SET_C = CW'(SETTLE_CYC);
  localparam logic [CW-1:0] TOG_C = CW'(TOGGLE_CYC);
  localparam logic [CW-1:0] MAX_C = {CW{1'b1}};

  typedef enum logic [3:0] {
    S_IDLE_SRC, S_AW_SRC, S_ATT_SRC, S_UNOR_SRC, S_OR_SRC,
    S_IDLE_SNK, S_IDLE_ACC, S_AW_ACC, S_ACC_DBG, S_AW_SNK, S_ATT_SNK, S_DBG_SNK
  } daao_tgt_state_t;

  localparam daao_tgt_state_t S_HOME = (KIND == DAAO_KIND_SRC) ? S_IDLE_SRC : S_IDLE_SNK;

  daao_term_t      cc1_s1_r, cc1_s2_r, cc1_s3_r;
  daao_term_t      cc2_s1_r, cc2_s2_r, cc2_s3_r;
  logic            vb_s1_r, vb_s2_r, vb_s3_r;
  daao_tgt_state_t st_r, st_nxt;
  logic [CW-1:0]   cnt_r, cnt_nxt;
  daao_term_t      term_r, term_nxt;
  logic            vbus_en_r;
  logic            orient_r, orient_nxt;
  logic            plug2_r, plug2_nxt;
  logic            att_r, aw_r, dbg_r, pd_r, dcon_r;

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      cc1_s1_r <= DAAO_TERM_OPEN;
      cc1_s2_r <= DAAO_TERM_OPEN;
      cc1_s3_r <= DAAO_TERM_OPEN;
      cc2_s1_r <= DAAO_TERM_OPEN;
      cc2_s2_r <= DAAO_TERM_OPEN;
      cc2_s3_r <= DAAO_TERM_OPEN;
      vb_s1_r  <= 1'b0;
      vb_s2_r  <= 1'b0;
      vb_s3_r  <= 1'b0;
    end else begin
      cc1_s1_r <= CC.dts_cc1;
      cc1_s2_r <= cc1_s1_r;
      cc1_s3_r <= cc1_s2_r;
      cc2_s1_r <= CC.dts_cc2;
      cc2_s2_r <= cc2_s1_r;
      cc2_s3_r <= cc2_s2_r;
      vb_s1_r  <= CC.vbus;
      vb_s2_r  <= vb_s1_r;
      vb_s3_r  <= vb_s2_r;
    end
  end

  wire rd1       = (cc1_s2_r == DAAO_TERM_RD);
  wire rd2       = (cc2_s2_r == DAAO_TERM_RD);
  wire ra1       = (cc1_s2_r == DAAO_TERM_RA);
  wire ra2       = (cc2_s2_r == DAAO_TERM_RA);
  wire pu1       = daao_is_pu(cc1_s2_r);
  wire pu2       = daao_is_pu(cc2_s2_r);
  wire both_pd   = daao_is_pd(cc1_s2_r) && daao_is_pd(cc2_s2_r);
  wire both_pu   = pu1 && pu2;
  wire both_open = (cc1_s2_r == DAAO_TERM_OPEN) && (cc2_s2_r == DAAO_TERM_OPEN);
  wire one_rd    = rd1 ^ rd2;
  wire one_rd_ok = one_rd && !both_pd;
  wire asym_ra   = (ra1 && rd2) || (rd1 && ra2);
  wire deb_done  = (cnt_r >= DEB_C);
  wire set_done  = (cnt_r >= SET_C);
  wire tog_done  = (cnt_r >= TOG_C);
  wire in_change = (cc1_s2_r != cc1_s3_r) || (cc2_s2_r != cc2_s3_r) || (vb_s2_r != vb_s3_r);
  // The stronger pull-up gives the higher sensed voltage.
  wire cc2_high  = (cc2_s2_r == DAAO_TERM_RP_STRONG) && (cc1_s2_r == DAAO_TERM_RP_WEAK);
  wire cc1_high  = (cc1_s2_r == DAAO_TERM_RP_STRONG) && (cc2_s2_r == DAAO_TERM_RP_WEAK);

  always_comb begin
    st_nxt = st_r;
    unique case (st_r)
      S_IDLE_SRC: begin
        if (both_pd || one_rd) st_nxt = S_AW_SRC;
      end
      S_AW_SRC: begin
        if (both_open) st_nxt = S_IDLE_SRC;
        else if (deb_done && one_rd_ok) st_nxt = S_ATT_SRC;
        else if (deb_done && both_pd && DAM_EN) st_nxt = S_UNOR_SRC;
      end
      S_ATT_SRC: begin
        if (!rd1 && !rd2) st_nxt = S_IDLE_SRC;
      end
      S_UNOR_SRC: begin
        if (both_open) st_nxt = S_IDLE_SRC;
        else if (asym_ra) st_nxt = S_OR_SRC;
      end
      S_OR_SRC: begin
        if (both_open) st_nxt = S_IDLE_SRC;
      end
      S_IDLE_SNK: begin
        if (pu1 || pu2) st_nxt = S_AW_SNK;
        else if (tog_done) st_nxt = S_IDLE_ACC;
      end
      S_IDLE_ACC: begin
        if (both_pd) st_nxt = S_AW_ACC;
        else if (tog_done) st_nxt = S_IDLE_SNK;
      end
      S_AW_ACC: begin
        if (!both_pd) st_nxt = S_IDLE_SNK;
        else if (deb_done) st_nxt = S_ACC_DBG;
      end
      S_ACC_DBG: begin
        if (!both_pd) st_nxt = S_IDLE_SNK;
      end
      S_AW_SNK: begin
        if (both_open) st_nxt = S_IDLE_SNK;
        else if (deb_done && vb_s2_r && (pu1 ^ pu2)) st_nxt = S_ATT_SNK;
        else if (deb_done && vb_s2_r && both_pu && DAM_EN) st_nxt = S_DBG_SNK;
      end
      S_ATT_SNK, S_DBG_SNK: begin
        if (both_open || !vb_s2_r) st_nxt = S_IDLE_SNK;
      end
      default: st_nxt = S_HOME;
    endcase
  end

  wire nxt_rp = (st_nxt == S_IDLE_SRC) || (st_nxt == S_AW_SRC) || (st_nxt == S_ATT_SRC) ||
                (st_nxt == S_UNOR_SRC) || (st_nxt == S_OR_SRC) || (st_nxt == S_IDLE_ACC) ||
                (st_nxt == S_AW_ACC) || (st_nxt == S_ACC_DBG);

  always_comb begin
    cnt_nxt    = (in_change || (st_nxt != st_r)) ? '0
               : ((cnt_r == MAX_C) ? cnt_r : cnt_r + 1'b1);
    term_nxt   = nxt_rp ? DAAO_TERM_RP_STRONG : DAAO_TERM_RD;
    orient_nxt = orient_r;
    plug2_nxt  = plug2_r;
    if (st_r == S_OR_SRC && !orient_r && (ra1 ^ ra2)) begin
      orient_nxt = 1'b1;
      plug2_nxt  = ra1;
    end else if (st_r == S_DBG_SNK && !orient_r && set_done && (cc1_high || cc2_high)) begin
      orient_nxt = 1'b1;
      plug2_nxt  = cc2_high;
    end
    if (st_nxt != S_OR_SRC && st_nxt != S_DBG_SNK) begin
      orient_nxt = 1'b0;
      plug2_nxt  = 1'b0;
    end
  end

  wire dbg_nxt = (st_nxt == S_UNOR_SRC) || (st_nxt == S_OR_SRC) ||
                 (st_nxt == S_ACC_DBG) || (st_nxt == S_DBG_SNK);
  wire att_nxt = dbg_nxt || (st_nxt == S_ATT_SRC) || (st_nxt == S_ATT_SNK);
  wire aw_nxt  = (st_nxt == S_AW_SRC) || (st_nxt == S_AW_ACC) || (st_nxt == S_AW_SNK);
  wire vb_nxt  = (st_nxt == S_ATT_SRC) || (st_nxt == S_UNOR_SRC) || (st_nxt == S_OR_SRC);
  // Debug connections and messaging wait for orientation in debug states.
  wire pd_nxt  = (st_nxt == S_ATT_SRC) || (st_nxt == S_ATT_SNK) || (dbg_nxt && orient_nxt);

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      st_r      <= S_HOME;
      cnt_r     <= '0;
      term_r    <= (KIND == DAAO_KIND_SRC) ? DAAO_TERM_RP_STRONG : DAAO_TERM_RD;
      vbus_en_r <= 1'b0;
      orient_r  <= 1'b0;
      plug2_r   <= 1'b0;
      att_r     <= 1'b0;
      aw_r      <= 1'b0;
      dbg_r     <= 1'b0;
      pd_r      <= 1'b0;
      dcon_r    <= 1'b0;
    end else begin
      st_r      <= st_nxt;
      cnt_r     <= cnt_nxt;
      term_r    <= term_nxt;
      vbus_en_r <= vb_nxt;
      orient_r  <= orient_nxt;
      plug2_r   <= plug2_nxt;
      att_r     <= att_nxt;
      aw_r      <= aw_nxt;
      dbg_r     <= dbg_nxt;
      pd_r      <= pd_nxt;
      dcon_r    <= dbg_nxt && orient_nxt;
    end
  end

  assign CC.tgt_cc1     = term_r;
  assign CC.tgt_cc2     = term_r;
  assign CC.tgt_vbus_en = vbus_en_r;
  assign ATTACH_WAIT    = aw_r;
  assign ATTACHED       = att_r;
  assign DEBUG_MODE     = dbg_r;
  assign ORIENTED       = orient_r;
  assign PLUG_CC2       = plug2_r;
  assign PD_EN          = pd_r;
  assign DBG_CONNECT    = dcon_r;

endmodule
`default_nettype wire

// [verif/daao_monitor.sv]
// Purpose: Concurrent checks on the CC link between a dual-role debug end and a target source.
// Assumes: Debug end has orientation on; target end is a source with debug mode.
// Notes:   Sees only the interface wires.
`timescale 1ns/1ps
`default_nettype none
module daao_monitor
  import daao_pkg::*;
#(
  parameter int DEB_CYC    = DAAO_DEB_CYC,
  parameter int TOGGLE_CYC = DAAO_TOGGLE_CYC
) (
  input wire logic       CLK,
  input wire logic       RST_N,
  input wire daao_term_t dts_cc1,
  input wire daao_term_t dts_cc2,
  input wire daao_term_t tgt_cc1,
  input wire daao_term_t tgt_cc2,
  input wire logic       dts_vbus_en,
  input wire logic       tgt_vbus_en,
  input wire logic       vbus
);
  logic       dts_pd2;
  logic       tgt_pu2;
  logic       dts_pu;
  logic [7:0] pu_run_r;
  logic [7:0] pu_run_nxt;

  assign dts_pd2 = (dts_cc1 == DAAO_TERM_RD) && (dts_cc2 == DAAO_TERM_RD);
  assign tgt_pu2 = (tgt_cc1 inside {DAAO_TERM_RP_STRONG, DAAO_TERM_RP_WEAK}) &&
                   (tgt_cc2 inside {DAAO_TERM_RP_STRONG, DAAO_TERM_RP_WEAK});
  assign dts_pu = dts_cc1 inside {DAAO_TERM_RP_STRONG, DAAO_TERM_RP_WEAK};
  // Counts how long the debug end has shown pull-ups without a break.
  assign pu_run_nxt = dts_pu ? pu_run_r + 8'h01 : 8'h00;

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) pu_run_r <= 8'h00;
    else pu_run_r <= pu_run_nxt;
  end

  default clocking mon_cb @(posedge CLK);
  endclocking
  default disable iff (!RST_N);

  sequence sink_waits_s;
    (dts_pd2 && tgt_pu2 && vbus) [*3];
  endsequence

  sequence sink_idle_s;
    (dts_pd2 && tgt_pu2 && !vbus) [*4];
  endsequence

  AST_IDLE_TOGGLE: assert property (int'(pu_run_r) <= TOGGLE_CYC + 4)
    else $error("debug end kept its source face too long");
  AST_SNK_ENTER: assert property (sink_idle_s |=> dts_cc1 == DAAO_TERM_RD)
    else $error("debug sink left its sink face while pull-ups were seen");
  AST_NO_VBUS_NO_ATTACH: assert property (!vbus [*5] |-> dts_cc2 != DAAO_TERM_RA)
    else $error("debug sink attached without VBUS");
  AST_SRC_ASYM: assert property (dts_pu |->
      dts_cc1 == DAAO_TERM_RP_STRONG && dts_cc2 == DAAO_TERM_RP_WEAK)
    else $error("debug source pull-ups are not strong then weak");
  AST_SNK_BOTH_RD: assert property (dts_cc1 == DAAO_TERM_RD |->
      dts_cc2 inside {DAAO_TERM_RD, DAAO_TERM_RA})
    else $error("debug sink second pin not pulled down");
  AST_SNK_NO_DRIVE: assert property (dts_cc1 == DAAO_TERM_RD |-> !dts_vbus_en)
    else $error("debug sink drives VBUS");
  AST_RA_NEEDS_VBUS: assert property ($rose(dts_cc2 == DAAO_TERM_RA) |->
      vbus && $past(vbus, 3))
    else $error("accessory level applied before VBUS was stable");
  AST_RA_FOLLOWS: assert property (sink_waits_s |-> ##[0:40] dts_cc2 == DAAO_TERM_RA)
    else $error("debug sink never lowered its second pin");
  AST_TGT_DEBOUNCE: assert property ($rose(tgt_vbus_en) |->
      $past(dts_pd2, 3) && $past(dts_pd2, DEB_CYC))
    else $error("target turned VBUS on before pull-downs were stable");
endmodule
`default_nettype wire

// [verif/testbench.sv]
// Purpose: Self-checking bench for the debug accessory attach and orientation ends.
// Assumes: Short interval counts so every walk fits in a few hundred cycles.
// Notes:   Two links join design ends; on four more the bench plays the far party.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import daao_pkg::*;
  localparam int DEB = 4;
  localparam int SET = 6;
  localparam int TOG = 8;
  localparam int AW  = 0;
  localparam int ATT = 1;
  localparam int SRC = 2;
  localparam int DBG = 2;
  localparam int ORI = 3;
  localparam int PL  = 4;
  localparam int PD  = 5;
  localparam int DC  = 6;
  logic [6:0] da, de, ta, tc, td, tg, dh;
  logic       clk         = 1'h0;
  logic       rst_n       = 1'h0;
  int         miscompares = 0;
  int         n_compared  = 0;
  int         i, n, m, k;
  logic       p;
  logic       exp_q[$];

  daao_cc_if ia ();
  daao_cc_if ic ();
  daao_cc_if id ();
  daao_cc_if ie ();
  daao_cc_if ig ();
  daao_cc_if ih ();

  daao_dts #(.ROLE(DAAO_ROLE_DRP), .DEB_CYC(DEB), .TOGGLE_CYC(TOG))
    daao_dts_inst (.CLK(clk), .RST_N(rst_n), .CC(ia.dts), .ATTACH_WAIT(da[AW]),
    .ATTACHED(da[ATT]), .IS_SOURCE(da[SRC]));
  daao_target #(.KIND(DAAO_KIND_SRC), .DAM_EN(1'h1), .DEB_CYC(DEB), .SETTLE_CYC(SET),
    .TOGGLE_CYC(TOG)) daao_target_inst (.CLK(clk), .RST_N(rst_n), .CC(ia.tgt),
    .ATTACH_WAIT(ta[0]), .ATTACHED(ta[1]), .DEBUG_MODE(ta[2]), .ORIENTED(ta[3]),
    .PLUG_CC2(ta[4]), .PD_EN(ta[5]), .DBG_CONNECT(ta[6]));
  daao_dts #(.ROLE(DAAO_ROLE_SRC), .ORIENT_EN(1'h1), .DEB_CYC(DEB), .TOGGLE_CYC(TOG))
    daao_dts_inst_c (.CLK(clk), .RST_N(rst_n), .CC(ic.dts), .ATTACH_WAIT(),
    .ATTACHED(), .IS_SOURCE());
  daao_target #(.KIND(DAAO_KIND_SNK_ACC), .DAM_EN(1'h1), .DEB_CYC(DEB), .SETTLE_CYC(SET),
    .TOGGLE_CYC(TOG)) daao_target_inst_c (.CLK(clk), .RST_N(rst_n), .CC(ic.tgt),
    .ATTACH_WAIT(tc[0]), .ATTACHED(tc[1]), .DEBUG_MODE(tc[2]), .ORIENTED(tc[3]),
    .PLUG_CC2(tc[4]), .PD_EN(tc[5]), .DBG_CONNECT(tc[6]));
  daao_target #(.KIND(DAAO_KIND_SRC), .DAM_EN(1'h0), .DEB_CYC(DEB), .SETTLE_CYC(SET),
    .TOGGLE_CYC(TOG)) daao_target_inst_d (.CLK(clk), .RST_N(rst_n), .CC(id.tgt),
    .ATTACH_WAIT(td[0]), .ATTACHED(td[1]), .DEBUG_MODE(td[2]), .ORIENTED(td[3]),
    .PLUG_CC2(td[4]), .PD_EN(td[5]), .DBG_CONNECT(td[6]));
  daao_dts #(.ROLE(DAAO_ROLE_DRP), .DEB_CYC(DEB), .TOGGLE_CYC(TOG))
    daao_dts_inst_e (.CLK(clk), .RST_N(rst_n), .CC(ie.dts), .ATTACH_WAIT(de[AW]),
    .ATTACHED(de[ATT]), .IS_SOURCE(de[SRC]));
  daao_target #(.KIND(DAAO_KIND_SNK_ACC), .DEB_CYC(DEB), .SETTLE_CYC(SET), .TOGGLE_CYC(TOG))
    daao_target_inst_g (.CLK(clk), .RST_N(rst_n), .CC(ig.tgt), .ATTACH_WAIT(tg[0]),
    .ATTACHED(tg[1]), .DEBUG_MODE(tg[2]), .ORIENTED(tg[3]), .PLUG_CC2(tg[4]),
    .PD_EN(tg[5]), .DBG_CONNECT(tg[6]));
  daao_dts #(.ROLE(DAAO_ROLE_SNK), .DEB_CYC(DEB), .TOGGLE_CYC(TOG))
    daao_dts_inst_h (.CLK(clk), .RST_N(rst_n), .CC(ih.dts), .ATTACH_WAIT(dh[AW]),
    .ATTACHED(dh[ATT]), .IS_SOURCE(dh[SRC]));
  daao_monitor #(.DEB_CYC(DEB), .TOGGLE_CYC(TOG)) daao_monitor_inst (.CLK(clk),
    .RST_N(rst_n), .dts_cc1(ia.dts_cc1), .dts_cc2(ia.dts_cc2), .tgt_cc1(ia.tgt_cc1),
    .tgt_cc2(ia.tgt_cc2), .dts_vbus_en(ia.dts_vbus_en), .tgt_vbus_en(ia.tgt_vbus_en),
    .vbus(ia.vbus));

  always #5 clk = ~clk;

  task automatic close_out;
    if (miscompares == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wt(ref logic [6:0] v, input int b, input logic e, input int lim);
    int j;
    for (j = 0; j < lim && v[b] !== e; j++) @(negedge clk);
    if (v[b] !== e) begin
      chk(v[b], e);
      close_out();
    end
  endtask

  task automatic drv_d(input daao_term_t a, input daao_term_t b, input logic v);
    @(negedge clk);
    id.dts_cc1 = a;
    id.dts_cc2 = b;
    id.dts_vbus_en = v;
  endtask

  task automatic drv_e(input daao_term_t a, input daao_term_t b, input logic v);
    @(negedge clk);
    ie.tgt_cc1 = a;
    ie.tgt_cc2 = b;
    ie.tgt_vbus_en = v;
  endtask

  // Higher rank stands for the higher sensed voltage on a pin.
  function automatic int rank(input daao_term_t t);
    return (t == DAAO_TERM_RP_STRONG) ? 3 : (t == DAAO_TERM_RP_WEAK) ? 2 :
           (t == DAAO_TERM_RD) ? 1 : 0;
  endfunction

  always @(negedge clk) begin
    if (rst_n) begin
      chk({6'h00, ta[PD] & ~ta[ORI], ta[DC] & ~ta[ORI]}, 8'h00);
      chk({6'h00, tc[PD] & ~tc[ORI], tc[DC] & ~tc[ORI]}, 8'h00);
    end
  end

  initial begin
    id.dts_cc1 = DAAO_TERM_OPEN;
    id.dts_cc2 = DAAO_TERM_OPEN;
    id.dts_vbus_en = 1'h0;
    ie.tgt_cc1 = DAAO_TERM_OPEN;
    ie.tgt_cc2 = DAAO_TERM_OPEN;
    ie.tgt_vbus_en = 1'h0;
    ig.dts_cc1 = DAAO_TERM_OPEN;
    ig.dts_cc2 = DAAO_TERM_OPEN;
    ig.dts_vbus_en = 1'h0;
    ih.tgt_cc1 = DAAO_TERM_OPEN;
    ih.tgt_cc2 = DAAO_TERM_OPEN;
    ih.tgt_vbus_en = 1'h0;
    void'($urandom(71));
    repeat (20) @(negedge clk);
    rst_n = 1'h1;
    wt(tc, DBG, 1'h1, 400);
    for (n = 0; n < 200 && tc[ORI] !== 1'h1; n++) @(negedge clk);
    chk(n >= SET, 1'h1);
    chk(tc[PL], rank(ic.dts_cc2) > rank(ic.dts_cc1));
    chk({ic.dts_cc1, ic.dts_cc2}, {DAAO_TERM_RP_STRONG, DAAO_TERM_RP_WEAK});
    wt(ta, ORI, 1'h1, 400);
    @(negedge clk);
    chk({ta[PD], ta[DC], ta[DBG]}, 3'h7);
    chk(ta[PL], rank(ia.dts_cc2) > rank(ia.dts_cc1));
    chk({da[ATT], da[SRC], ia.dts_cc1, ia.dts_cc2}, {2'h2, DAAO_TERM_RD, DAAO_TERM_RA});
    for (i = 0; i < 6; i++) begin
      m = (i < 3) ? i : $urandom % 3;
      exp_q.push_back(m != 0);
      drv_d((m != 2) ? DAAO_TERM_RD : DAAO_TERM_OPEN, (m != 1) ? DAAO_TERM_RD : DAAO_TERM_OPEN,
        1'h0);
      repeat (DEB + 8 + $urandom % 16) @(negedge clk);
      chk(td[ATT], exp_q.pop_front());
      chk({td[AW], id.vbus}, {m == 0, m != 0});
      drv_d(DAAO_TERM_OPEN, DAAO_TERM_OPEN, 1'h0);
      wt(td, ATT, 1'h0, 20);
      wt(td, AW, 1'h0, 20);
      chk({id.tgt_cc1, id.tgt_cc2}, {DAAO_TERM_RP_STRONG, DAAO_TERM_RP_STRONG});
    end
    k = 0;
    p = de[SRC];
    for (i = 0; i < 6 * TOG; i++) begin
      @(negedge clk);
      if (de[SRC] !== p) k++;
      p = de[SRC];
    end
    chk(k >= 3, 1'h1);
    drv_e(DAAO_TERM_RP_STRONG, DAAO_TERM_RP_STRONG, 1'h0);
    wt(de, AW, 1'h1, 4 * TOG + 10);
    chk(de[SRC], 1'h0);
    repeat (40) @(negedge clk);
    chk({de[AW], de[ATT]}, 2'h2);
    drv_e(DAAO_TERM_RP_STRONG, DAAO_TERM_RP_STRONG, 1'h1);
    wt(de, ATT, 1'h1, 40);
    chk({ie.dts_cc1, ie.dts_cc2}, {DAAO_TERM_RD, DAAO_TERM_RA});
    drv_e(DAAO_TERM_OPEN, DAAO_TERM_OPEN, 1'h1);
    wt(de, ATT, 1'h0, 20);
    chk({de[SRC], de[AW]}, 2'h2);
    drv_e(DAAO_TERM_OPEN, DAAO_TERM_OPEN, 1'h0);
    k = 0;
    p = (ig.tgt_cc1 == DAAO_TERM_RD);
    for (i = 0; i < 6 * TOG; i++) begin
      @(negedge clk);
      if ((ig.tgt_cc1 == DAAO_TERM_RD) !== p) k++;
      p = (ig.tgt_cc1 == DAAO_TERM_RD);
    end
    chk(k >= 3, 1'h1);
    @(negedge clk);
    ig.dts_cc1 = DAAO_TERM_RD;
    ig.dts_cc2 = DAAO_TERM_RD;
    wt(tg, DBG, 1'h1, 4 * TOG + 20);
    chk({tg[ATT], tg[ORI], tg[PD], tg[DC], ig.tgt_cc1}, {4'h8, DAAO_TERM_RP_STRONG});
    @(negedge clk);
    ig.dts_cc1 = DAAO_TERM_OPEN;
    ig.dts_cc2 = DAAO_TERM_OPEN;
    wt(tg, DBG, 1'h0, 20);
    chk({tg[ATT], ig.tgt_cc1}, {1'h0, DAAO_TERM_RD});
    @(negedge clk);
    ih.tgt_cc1 = DAAO_TERM_RP_STRONG;
    ih.tgt_cc2 = DAAO_TERM_RP_STRONG;
    ih.tgt_vbus_en = 1'h1;
    wt(dh, ATT, 1'h1, 40);
    chk({dh[SRC], ih.dts_cc1, ih.dts_cc2}, {1'h0, DAAO_TERM_RD, DAAO_TERM_RA});
    @(negedge clk);
    ih.tgt_cc1 = DAAO_TERM_OPEN;
    ih.tgt_cc2 = DAAO_TERM_OPEN;
    ih.tgt_vbus_en = 1'h0;
    wt(dh, ATT, 1'h0, 20);
    chk({dh[SRC], dh[AW], ih.dts_cc2}, {2'h0, DAAO_TERM_RD});
    close_out();
  end
endmodule
`default_nettype wire
